// File: ccal_regs.sv
// Paged current calibration and overcurrent limit register bank
// How it works
// - Gain word: exponent fixed -15, top two mantissa bits zero, nine writable, default 16.
// - Gain step is 30.5 micro-ohm, range 0.244 to 15.5 milli-ohm.
// - Monitoring amplifier gain 25, 15 or 10 chosen from gain value.
// - Store commands copy registers to non-volatile memory; gain also factory store.
// - Offset correction applies to current reading and fault compare.
// - Offset exponent fixed -4, step 62.5 mA, reset value zero.
// - Offset mantissa: writable sign, four sign copies, six writable low bits.
// - Out-of-range offset writes wrap; top five mantissa bits follow the sign.
// - Fault limit exponent fixed -1, upper four bits zero, seven writable, default 60.
// - Fault threshold is half the mantissa in amperes, 3 A to 50 A.
// - Overcurrent flagged when corrected current exceeds fault limit.
// - Fault limit below warning sets CML, invalid data and alert.
// - Overcurrent fault sets status byte, word, current status bits and alert.
`timescale 1ns/1ps
module ccal_regs (
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	input  wire ccal_pkg::ccal_req_s req,
	input  wire logic                page,
	input  wire logic [6:0]          warn_mant,
	input  wire logic [11:0]         iout_raw,
	input  wire logic                status_clr,
	input  wire logic                store_user,
	input  wire logic                store_factory,
	output logic [15:0]              rd_data,
	output logic                     rd_valid,
	output logic [1:0]               amp_sel,
	output logic [11:0]              iout_corr,
	output logic                     oc_fault,
	output ccal_pkg::ccal_status_s   status,
	output logic                     smb_alert,
	output logic [47:0]              nvm_data,
	output logic                     nvm_gain_only,
	output logic                     nvm_we
);
	logic [8:0]  gain_q   [ccal_pkg::NUM_PAGES];
	logic        osign_q  [ccal_pkg::NUM_PAGES];
	logic [5:0]  olow_q   [ccal_pkg::NUM_PAGES];
	logic [6:0]  oclim_q  [ccal_pkg::NUM_PAGES];
	logic [6:0]  pend_q;
	logic        pend_page_q;
	logic        page_q;
	ccal_pkg::ccal_state_e state_q;
	logic        wr_gain;
	logic        wr_off;
	logic        wr_oc;

	// Assemble a register word with fixed fields forced
	function automatic logic [15:0] rd_word(input logic [7:0] cmd, input logic p);
		logic [15:0] w;
		w = 16'h0000;
		if (cmd == ccal_pkg::CMD_GAIN)
			w = {ccal_pkg::GAIN_EXP, 2'b00, gain_q[p]};
		else if (cmd == ccal_pkg::CMD_OFFSET)
			w = {ccal_pkg::OFFSET_EXP, {5{osign_q[p]}}, olow_q[p]};
		else if (cmd == ccal_pkg::CMD_OCFLT)
			w = {ccal_pkg::OCFLT_EXP, 4'h0, oclim_q[p]};
		return w;
	endfunction

	assign wr_gain = req.valid && req.write && req.cmd == ccal_pkg::CMD_GAIN;
	assign wr_off  = req.valid && req.write && req.cmd == ccal_pkg::CMD_OFFSET;
	assign wr_oc   = req.valid && req.write && req.cmd == ccal_pkg::CMD_OCFLT;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			page_q <= 1'b0;
		else
			page_q <= page;
	end

	genvar g;
	generate
		for (g = 0; g < ccal_pkg::NUM_PAGES; g++)
		begin : g_page
			always_ff @(posedge ref_clk or negedge rst_b)
			begin
				if (!rst_b)
					gain_q[g] <= ccal_pkg::GAIN_RST[ccal_pkg::GAIN_W_MSB:0];
				else if (wr_gain && page == 1'(g))
					gain_q[g] <= req.data[ccal_pkg::GAIN_W_MSB:0];
			end
			// sign and low bits only; wraps by construction
			always_ff @(posedge ref_clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					osign_q[g] <= ccal_pkg::OFFSET_RST[ccal_pkg::OFF_SIGN_POS];
					olow_q[g]  <= ccal_pkg::OFFSET_RST[ccal_pkg::OFF_LOW_MSB:0];
				end
				else if (wr_off && page == 1'(g))
				begin
					osign_q[g] <= req.data[ccal_pkg::OFF_SIGN_POS];
					olow_q[g]  <= req.data[ccal_pkg::OFF_LOW_MSB:0];
				end
			end
			// commit only after the warning check passes
			always_ff @(posedge ref_clk or negedge rst_b)
			begin
				if (!rst_b)
					oclim_q[g] <= ccal_pkg::OCFLT_RST[ccal_pkg::OCFLT_W_MSB:0];
				else if (state_q == ccal_pkg::CCAL_ST_CHECK && pend_page_q == 1'(g)
					&& pend_q >= warn_mant)
					oclim_q[g] <= pend_q;
			end
		end
	endgenerate

	// Fault-limit writes are checked one cycle later against the warning limit
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q     <= ccal_pkg::CCAL_ST_IDLE;
			pend_q      <= 7'h00;
			pend_page_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				ccal_pkg::CCAL_ST_IDLE:
					if (wr_oc)
					begin
						state_q     <= ccal_pkg::CCAL_ST_CHECK;
						pend_q      <= req.data[ccal_pkg::OCFLT_W_MSB:0];
						pend_page_q <= page;
					end
				ccal_pkg::CCAL_ST_CHECK:
					state_q <= ccal_pkg::CCAL_ST_DONE;
				default:
					state_q <= ccal_pkg::CCAL_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= req.valid && !req.write;
			if (req.valid && !req.write)
				rd_data <= rd_word(req.cmd, page);
		end
	end

	ccal_gain_sel u_gain_sel (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.gain_mant (gain_q[page_q]),
		.amp_sel   (amp_sel)
	);

	// offset added to sensed current; sign-extended, units of 62.5 mA
	logic [11:0] off_ext;
	logic [11:0] corr;
	assign off_ext = {{6{osign_q[page_q]}}, olow_q[page_q]};
	assign corr    = iout_raw + off_ext;

	// compare corrected current (62.5 mA units) with limit (500 mA units)
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			iout_corr <= 12'h000;
			oc_fault  <= 1'b0;
		end
		else
		begin
			iout_corr <= corr;
			oc_fault  <= !corr[11] && (corr > {2'b00, oclim_q[page_q], 3'b000});
		end
	end

	// invalid limit and overcurrent status; set wins over clear
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			status <= '0;
		else
		begin
			if (state_q == ccal_pkg::CCAL_ST_CHECK && pend_q < warn_mant)
			begin
				status.cml <= 1'b1;
				status.ivd <= 1'b1;
			end
			else if (status_clr)
			begin
				status.cml <= 1'b0;
				status.ivd <= 1'b0;
			end
			if (oc_fault)
			begin
				status.iout_oc   <= 1'b1;
				status.iout_pout <= 1'b1;
				status.oc_fault  <= 1'b1;
			end
			else if (status_clr)
			begin
				status.iout_oc   <= 1'b0;
				status.iout_pout <= 1'b0;
				status.oc_fault  <= 1'b0;
			end
		end
	end

	// Alert tracks status one cycle later; any sticky bit holds it
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			smb_alert <= 1'b0;
		else
			smb_alert <= |status;
	end

	// store snapshot of the selected page
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			nvm_data      <= 48'h0;
			nvm_we        <= 1'b0;
			nvm_gain_only <= 1'b0;
		end
		else
		begin
			nvm_we        <= store_user || store_factory;
			nvm_gain_only <= store_factory && !store_user;
			if (store_user || store_factory)
				nvm_data <= {rd_word(ccal_pkg::CMD_GAIN, page),
					rd_word(ccal_pkg::CMD_OFFSET, page), rd_word(ccal_pkg::CMD_OCFLT, page)};
		end
	end
endmodule // ccal_regs

// File: ccal_pkg.sv
// Package for the paged current calibration and overcurrent limit registers
package ccal_pkg;
	localparam int NUM_PAGES = 2;
	localparam logic [7:0] CMD_GAIN   = 8'h38;
	localparam logic [7:0] CMD_OFFSET = 8'h39;
	localparam logic [7:0] CMD_OCFLT  = 8'h46;
	localparam logic [7:0] CMD_OCWARN = 8'h4A;
	localparam logic [4:0] GAIN_EXP   = 5'h11;
	localparam logic [4:0] OFFSET_EXP = 5'h1C;
	localparam logic [4:0] OCFLT_EXP  = 5'h1F;
	localparam logic [15:0] GAIN_RST   = 16'h8810;
	localparam logic [15:0] OFFSET_RST = 16'hE000;
	localparam logic [15:0] OCFLT_RST  = 16'hF83C;
	localparam logic [6:0] OCWARN_RST  = 7'h36;
	localparam int GAIN_W_MSB   = 8;
	localparam int OCFLT_W_MSB  = 6;
	localparam int OFF_SIGN_POS = 10;
	localparam int OFF_LOW_MSB  = 5;
	// Gain mantissa thresholds: 0.5795 mohm = 19 steps, 1.1285 mohm = 37 steps
	localparam logic [8:0] GAIN_TH_HI = 9'h013;
	localparam logic [8:0] GAIN_TH_MID = 9'h025;
	localparam logic [1:0] AMP_X25 = 2'h0;
	localparam logic [1:0] AMP_X15 = 2'h1;
	localparam logic [1:0] AMP_X10 = 2'h2;

	typedef enum logic [1:0] {
		CCAL_ST_IDLE  = 2'b00,
		CCAL_ST_CHECK = 2'b01,
		CCAL_ST_DONE  = 2'b10
	} ccal_state_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  cmd;
		logic [15:0] data;
	} ccal_req_s;

	typedef struct packed {
		logic        cml;
		logic        iout_oc;
		logic        iout_pout;
		logic        oc_fault;
		logic        ivd;
	} ccal_status_s;
endpackage

// File: ccal_gain_sel.sv
// Sense amplifier gain selection from the gain calibration mantissa
`timescale 1ns/1ps
module ccal_gain_sel (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic [8:0] gain_mant,
	output logic      [1:0] amp_sel
);
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			amp_sel <= ccal_pkg::AMP_X25;
		else if (gain_mant <= ccal_pkg::GAIN_TH_HI)
			amp_sel <= ccal_pkg::AMP_X25;
		else if (gain_mant <= ccal_pkg::GAIN_TH_MID)
			amp_sel <= ccal_pkg::AMP_X15;
		else
			amp_sel <= ccal_pkg::AMP_X10;
	end
endmodule // ccal_gain_sel

// File: ccal_regs_assertions.sv
// Checker for the paged calibration register bank
`timescale 1ns/1ps
module ccal_regs_chk (
	input wire logic                   ref_clk,
	input wire logic                   rst_b,
	input wire ccal_pkg::ccal_req_s    req,
	input wire logic [15:0]            rd_data,
	input wire logic                   rd_valid,
	input wire logic                   oc_fault,
	input wire ccal_pkg::ccal_status_s status,
	input wire logic                   status_clr,
	input wire logic                   smb_alert
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	read_answer_a: assert property (req.valid && !req.write |=> rd_valid)
		else $error("read not answered");
	read_cause_a: assert property (rd_valid |-> $past(req.valid && !req.write))
		else $error("stray read answer");
	gain_fixed_a: assert property (rd_valid && $past(req.cmd) == ccal_pkg::CMD_GAIN
		|-> rd_data[15:9] == 7'h44) else $error("gain fixed bits wrong");
	offset_fixed_a: assert property (rd_valid && $past(req.cmd) == ccal_pkg::CMD_OFFSET
		|-> rd_data[15:11] == 5'h1C && rd_data[9:6] == {4{rd_data[10]}})
		else $error("offset fixed bits wrong");
	limit_fixed_a: assert property (rd_valid && $past(req.cmd) == ccal_pkg::CMD_OCFLT
		|-> rd_data[15:7] == 9'h1F0) else $error("limit fixed bits wrong");
	alert_follow_a: assert property (smb_alert == $past(|status))
		else $error("alert does not follow status");
	cml_sticky_a: assert property (status.cml && !status_clr |=> status.cml)
		else $error("cml bit lost");
	oc_status_a: assert property (oc_fault |-> ##[0:2] status.oc_fault && status.iout_oc)
		else $error("overcurrent not reported");
endmodule // ccal_regs_chk
bind ccal_regs ccal_regs_chk ccal_regs_chk_inst (.ref_clk, .rst_b, .req, .rd_data, .rd_valid,
	.oc_fault, .status, .status_clr, .smb_alert);

// File: ccal_host.sv
// Host model issuing one register command at a time
`timescale 1ns/1ps
module ccal_host (
	input  wire logic          ref_clk,
	output ccal_pkg::ccal_req_s req,
	output logic               page
);
	initial
	begin
		req = '0;
		page = 1'b0;
	end
	// idle gap spacing
	// Keeps fault-limit writes at least three cycles apart
	task automatic cmd(input logic w, input logic pg, input logic [7:0] c, input logic [15:0] d);
		@(negedge ref_clk);
		req <= '{1'b1, w, c, d};
		page <= pg;
		@(negedge ref_clk);
		// Released fields flip so stale values never look valid
		req <= '{1'b0, ~w, ~c, ~d};
		repeat (3) @(negedge ref_clk);
	endtask
endmodule // ccal_host

// File: ccal_regs_tb.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/1ps
module ccal_regs_tb;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [6:0] warn_mant = 7'h36;
	logic [11:0] iout_raw = 12'h000;
	logic status_clr = 1'b0;
	logic store_user = 1'b0;
	logic store_factory = 1'b0;
	ccal_pkg::ccal_req_s req;
	ccal_pkg::ccal_status_s status;
	logic page, rd_valid, oc_fault, smb_alert, nvm_gain_only, nvm_we;
	logic [15:0] rd_data, w;
	logic [1:0] amp_sel;
	logic [11:0] iout_corr;
	logic [47:0] nvm_data;
	logic [15:0] exp_q[$];
	logic [8:0] gt[4] = '{9'h013, 9'h014, 9'h025, 9'h026};
	logic [1:0] ga[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
	int n_fail = 0;
	int cmp_count = 0;
	always #5 ref_clk = ~ref_clk;
	ccal_host ccal_host_inst (.ref_clk, .req, .page);
	ccal_regs ccal_regs_inst (.ref_clk, .rst_b, .req, .page, .warn_mant, .iout_raw, .status_clr,
		.store_user, .store_factory, .rd_data, .rd_valid, .amp_sel, .iout_corr, .oc_fault,
		.status, .smb_alert, .nvm_data, .nvm_gain_only, .nvm_we);
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic rd(input logic pg, input logic [7:0] c, input logic [15:0] e);
		exp_q.push_back(e);
		ccal_host_inst.cmd(1'b0, pg, c, 16'h0000);
	endtask
	task automatic store(input logic f, input logic [15:0] e);
		store_user = !f;
		store_factory = f;
		@(negedge ref_clk);
		store_user = 1'b0;
		store_factory = 1'b0;
		for (int i = 0; i < 4 && nvm_we !== 1'b1; i++) @(negedge ref_clk);
		check(16'({nvm_we, nvm_gain_only}), 16'({1'b1, f}));
		check(nvm_data[15:0], e);
	endtask
	task automatic stop_test;
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(negedge ref_clk)
		if (rd_valid === 1'b1)
			check(rd_data, exp_q.pop_front());
	initial
	begin
		#20us;
		n_fail++;
		stop_test();
	end
	initial
	begin
		void'($urandom(1968));
		repeat (8) @(negedge ref_clk);
		rst_b = 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			rd(p[0], ccal_pkg::CMD_GAIN, 16'h8810);
			rd(p[0], ccal_pkg::CMD_OFFSET, 16'hE000);
			rd(p[0], ccal_pkg::CMD_OCFLT, 16'hF83C);
		end
		w = 16'($urandom);
		ccal_host_inst.cmd(1'b1, 1'b0, ccal_pkg::CMD_GAIN, w | 16'hFE00);
		rd(1'b0, ccal_pkg::CMD_GAIN, {7'h44, w[8:0]});
		rd(1'b1, ccal_pkg::CMD_GAIN, 16'h8810);
		foreach (gt[i])
		begin
			ccal_host_inst.cmd(1'b1, 1'b0, ccal_pkg::CMD_GAIN, {7'h00, gt[i]});
			check(16'(amp_sel), 16'(ga[i]));
		end
		ccal_host_inst.cmd(1'b1, 1'b0, ccal_pkg::CMD_OFFSET, 16'hE401);
		rd(1'b0, ccal_pkg::CMD_OFFSET, 16'hE7C1);
		iout_raw = 12'h064;
		repeat (3) @(negedge ref_clk);
		check(16'(iout_corr), 16'h0025);
		ccal_host_inst.cmd(1'b1, 1'b0, ccal_pkg::CMD_OCFLT, 16'hFFC0);
		rd(1'b0, ccal_pkg::CMD_OCFLT, 16'hF840);
		iout_raw = 12'h23F;
		repeat (4) @(negedge ref_clk);
		check(16'(oc_fault), 16'h0000);
		iout_raw = 12'h240;
		repeat (4) @(negedge ref_clk);
		check(16'({oc_fault, status.iout_oc, status.iout_pout, status.oc_fault}), 16'h000F);
		iout_raw = 12'h000;
		status_clr = 1'b1;
		repeat (3) @(negedge ref_clk);
		status_clr = 1'b0;
		repeat (2) @(negedge ref_clk);
		check(16'({status, smb_alert}), 16'h0000);
		ccal_host_inst.cmd(1'b1, 1'b0, ccal_pkg::CMD_OCFLT, 16'h0035);
		check(16'({status.cml, status.ivd, smb_alert}), 16'h0007);
		rd(1'b0, ccal_pkg::CMD_OCFLT, 16'hF840);
		ccal_host_inst.cmd(1'b1, 1'b1, ccal_pkg::CMD_OCFLT, 16'h0036);
		rd(1'b1, ccal_pkg::CMD_OCFLT, 16'hF836);
		w = 16'($urandom);
		ccal_host_inst.cmd(1'b1, 1'b1, ccal_pkg::CMD_OFFSET, w);
		rd(1'b1, ccal_pkg::CMD_OFFSET, {5'h1C, {5{w[10]}}, w[5:0]});
		store(1'b0, 16'hF836);
		store(1'b1, 16'hF836);
		rst_b = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_b = 1'b1;
		rd(1'b1, ccal_pkg::CMD_OCFLT, 16'hF83C);
		stop_test();
	end
endmodule // ccal_regs_tb
